// *** hdl/pin_function_config.sv ***
// Pad control for three general-purpose ports plus reset, NMI, timer and test pins.
// Assumes the core supplies per-line mode codes and output data synchronous to clock_i.
`timescale 1ns/1ps
`include "pin_function_config_consts.svh"

module pin_function_config
  import pin_function_config_pkg::*;
#(
  parameter bit STOP_CTRL_OPTION = 1'b0, // Build-time stop control option
  parameter bit LARGE_PACKAGE    = 1'b1  // Zero drops third port and upper first-port lines
) (
  input  wire logic                                  clock_i,        // Core clock
  input  wire logic                                  rst_i,          // System reset, high
  input  wire logic                                  reset_pin_n_i,  // External reset pin, low
  input  wire logic [`PORT_ONE_WIDTH*`MODE_WIDTH-1:0]   p1_mode_i,   // First port modes
  input  wire logic [`PORT_TWO_WIDTH*`MODE_WIDTH-1:0]   p2_mode_i,   // Second port modes
  input  wire logic [`PORT_THREE_WIDTH*`MODE_WIDTH-1:0] p3_mode_i,   // Third port modes
  input  wire logic [`PORT_ONE_WIDTH-1:0]            p1_data_i,      // First port out data
  input  wire logic [`PORT_TWO_WIDTH-1:0]            p2_data_i,      // Second port out data
  input  wire logic [`PORT_THREE_WIDTH-1:0]          p3_data_i,      // Third port out data
  input  wire logic [`PORT_ONE_WIDTH-1:0]            p1_pin_i,       // First port pad in
  input  wire logic [`PORT_TWO_WIDTH-1:0]            p2_pin_i,       // Second port pad in
  input  wire logic [`PORT_THREE_WIDTH-1:0]          p3_pin_i,       // Third port pad in
  input  wire logic                                  nmi_pin_i,      // NMI pad
  input  wire logic                                  nmi_ack_i,      // Core took NMI
  input  wire logic                                  timer_out_mode_i, // Timer pin as output
  input  wire logic                                  timer_timeout_i,  // Counter time-out pulse
  input  wire logic                                  timer_data_bit_i, // Programmed data bit
  input  wire logic                                  timer_pin_i,    // Timer pad in
  input  wire logic                                  test_pin_i,     // Test strap
  output logic      [`PORT_ONE_WIDTH-1:0]            p1_out_o,       // First port pad out
  output logic      [`PORT_ONE_WIDTH-1:0]            p1_oe_o,        // First port drive enable
  output logic      [`PORT_ONE_WIDTH-1:0]            p1_pull_o,      // First port pull-up
  output logic      [`PORT_ONE_WIDTH-1:0]            p1_ana_o,       // First port analog sel
  output logic      [`PORT_ONE_WIDTH-1:0]            p1_din_o,       // First port read data
  output logic      [`PORT_ONE_WIDTH-1:0]            p1_irq_o,       // First port irq level
  output logic      [`PORT_TWO_WIDTH-1:0]            p2_out_o,       // Second port pad out
  output logic      [`PORT_TWO_WIDTH-1:0]            p2_oe_o,        // Second port drive enable
  output logic      [`PORT_TWO_WIDTH-1:0]            p2_pull_o,      // Second port pull-up
  output logic      [`PORT_TWO_WIDTH-1:0]            p2_ana_o,       // Second port analog sel
  output logic      [`PORT_TWO_WIDTH-1:0]            p2_din_o,       // Second port read data
  output logic      [`PORT_TWO_WIDTH-1:0]            p2_irq_o,       // Second port irq level
  output logic      [`PORT_THREE_WIDTH-1:0]          p3_out_o,       // Third port pad out
  output logic      [`PORT_THREE_WIDTH-1:0]          p3_oe_o,        // Third port drive enable
  output logic      [`PORT_THREE_WIDTH-1:0]          p3_pull_o,      // Third port pull-up
  output logic      [`PORT_THREE_WIDTH-1:0]          p3_ana_o,       // Third port analog sel
  output logic      [`PORT_THREE_WIDTH-1:0]          p3_din_o,       // Third port read data
  output logic      [`PORT_THREE_WIDTH-1:0]          p3_irq_o,       // Third port irq level
  output logic                                       nmi_req_o,      // NMI pending, level
  output logic                                       timer_ext_o,    // Pin to prescaler
  output logic                                       timer_out_o,    // Timer pad out
  output logic                                       timer_oe_o,     // Timer pad drive enable
  output logic                                       test_mode_o     // Non-user mode seen
);

  // ----------------------------------------------------------------
  // Line decode
  // ----------------------------------------------------------------
  // One pad's controls: out, oe, pull, analog, din, irq as six bits
  function automatic logic [5:0] decode_line(input line_mode_t mode, input logic data,
                                             input logic pin, input logic ana_ok,
                                             input logic force_od, input logic present);
    logic od;
    logic [5:0] r;
    r  = 6'h00;
    od = (mode == `MODE_OUT_OD) || (force_od && mode == `MODE_OUT_PP);
    if (present) begin
      unique case (mode)
        `MODE_IN_FLOAT:  r = {4'h0, pin, 1'b0};
        `MODE_IN_PULLUP: r = {2'h0, 1'b1, 1'b0, pin, 1'b0};
        `MODE_IN_IRQ:    r = {2'h0, 1'b1, 1'b0, pin, ~pin};          // Low level requests
        `MODE_OUT_OD,
        `MODE_OUT_PP:    r = od ? {1'b0, ~data, 2'h0, pin, 1'b0}     // Drive low only
                                : {data, 1'b1, 2'h0, pin, 1'b0};
        `MODE_ANALOG:    r = ana_ok ? 6'h04 : {4'h0, pin, 1'b0};      // Digital read off
        default:         r = {4'h0, pin, 1'b0};                        // Unused codes float
      endcase
    end
    return r;
  endfunction : decode_line

  state_t s_q;
  state_t s_d;
  logic [5:0] l1 [`PORT_ONE_WIDTH];
  logic [5:0] l2 [`PORT_TWO_WIDTH];
  logic [5:0] l3 [`PORT_THREE_WIDTH];

  // Pin reset joins the system reset; a glitch-free pad is assumed
  wire logic any_rst = rst_i | ~reset_pin_n_i;

  // ----------------------------------------------------------------
  // Per-line decode, one generate per port
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PORT_ONE_WIDTH; g++) begin : g_p1
      localparam bit HIGH = (g >= `PORT_ONE_HIGH_LO);
      assign l1[g] = decode_line(line_mode_t'(p1_mode_i[g*`MODE_WIDTH +: `MODE_WIDTH]),
                                 p1_data_i[g], p1_pin_i[g], HIGH,
                                 1'b0, !HIGH || LARGE_PACKAGE);
    end
    for (g = 0; g < `PORT_TWO_WIDTH; g++) begin : g_p2
      localparam bit FOD = STOP_CTRL_OPTION && (g == `PORT_TWO_ZERO);
      assign l2[g] = decode_line(line_mode_t'(p2_mode_i[g*`MODE_WIDTH +: `MODE_WIDTH]),
                                 p2_data_i[g], p2_pin_i[g], 1'b1, FOD, 1'b1);
    end
    for (g = 0; g < `PORT_THREE_WIDTH; g++) begin : g_p3
      localparam bit FOD = STOP_CTRL_OPTION && (g == `PORT_THREE_TOP);
      assign l3[g] = decode_line(line_mode_t'(p3_mode_i[g*`MODE_WIDTH +: `MODE_WIDTH]),
                                 p3_data_i[g], p3_pin_i[g], 1'b1, FOD,
                                 LARGE_PACKAGE);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Timer pad only drives in output mode and holds the bit between time-outs
  always_comb begin
    s_d = s_q;
    for (int i = 0; i < `PORT_ONE_WIDTH; i++) begin
      {s_d.p1.out[i], s_d.p1.oe[i], s_d.p1.pull[i], s_d.p1.ana[i], s_d.p1.din[i], s_d.p1.irq[i]} = l1[i];
    end
    for (int i = 0; i < `PORT_TWO_WIDTH; i++) begin
      {s_d.p2.out[i], s_d.p2.oe[i], s_d.p2.pull[i], s_d.p2.ana[i], s_d.p2.din[i], s_d.p2.irq[i]} = l2[i];
    end
    for (int i = 0; i < `PORT_THREE_WIDTH; i++) begin
      {s_d.p3.out[i], s_d.p3.oe[i], s_d.p3.pull[i], s_d.p3.ana[i], s_d.p3.din[i], s_d.p3.irq[i]} = l3[i];
    end
    // NMI falling edge sets pending; set beats a same-cycle acknowledge
    s_d.nmi_s1   = nmi_pin_i;
    s_d.nmi_prev = s_q.nmi_s1;
    if (s_q.nmi_prev && !s_q.nmi_s1) begin
      s_d.nmi_pend = 1'b1;
    end else if (nmi_ack_i) begin
      s_d.nmi_pend = 1'b0;
    end
    s_d.tmr_ext = timer_out_mode_i ? 1'b0 : timer_pin_i;
    s_d.tmr_oe  = timer_out_mode_i;
    if (timer_out_mode_i && timer_timeout_i) begin
      s_d.tmr_out = timer_data_bit_i;
    end
    s_d.test_mode = test_pin_i;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // NMI idles high, so the history starts high to avoid a false edge
  always_ff @(posedge clock_i or posedge any_rst) begin
    if (any_rst) begin
      s_q          <= '0;
      s_q.nmi_s1   <= 1'b1;
      s_q.nmi_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign p1_out_o    = s_q.p1.out;
  assign p1_oe_o     = s_q.p1.oe;
  assign p1_pull_o   = s_q.p1.pull;
  assign p1_ana_o    = s_q.p1.ana;
  assign p1_din_o    = s_q.p1.din;
  assign p1_irq_o    = s_q.p1.irq;
  assign p2_out_o    = s_q.p2.out;
  assign p2_oe_o     = s_q.p2.oe;
  assign p2_pull_o   = s_q.p2.pull;
  assign p2_ana_o    = s_q.p2.ana;
  assign p2_din_o    = s_q.p2.din;
  assign p2_irq_o    = s_q.p2.irq;
  assign p3_out_o    = s_q.p3.out;
  assign p3_oe_o     = s_q.p3.oe;
  assign p3_pull_o   = s_q.p3.pull;
  assign p3_ana_o    = s_q.p3.ana;
  assign p3_din_o    = s_q.p3.din;
  assign p3_irq_o    = s_q.p3.irq;
  assign nmi_req_o   = s_q.nmi_pend;
  assign timer_ext_o = s_q.tmr_ext;
  assign timer_out_o = s_q.tmr_out;
  assign timer_oe_o  = s_q.tmr_oe;
  assign test_mode_o = s_q.test_mode;

endmodule : pin_function_config

// *** hdl/pin_function_config_consts.svh ***
// Constants for the pin function block: line counts, mode codes, reset values.
// Assumes inclusion by the package and the top module, compiled before both.
// How it works
// - First port has eight lines: input, pull-up input, interrupt input, open-drain, push-pull.
// - Upper four lines of the first port may also be analog inputs.
// - Without stop control, second port lines offer every mode including analog.
// - With stop control, second port line zero is always open-drain when driving.
// - Third port has four lines offering every mode without stop control.
// - With stop control, third port top line is always open-drain when driving.
// - A parameter removes the third port and upper first-port lines for small packages.
// - Non-maskable interrupt is sampled on clock_i through two flops and caught on a falling edge, never masked.
// - Low level on the reset pin restarts the device from reset state.
// - Timer pin as input feeds the prescaler as external clock or gate.
// - Timer pin as output drives the programmed data bit on each time-out.
`ifndef PIN_FUNCTION_CONFIG_CONSTS_SVH
`define PIN_FUNCTION_CONFIG_CONSTS_SVH

`define PORT_ONE_WIDTH   8
`define PORT_TWO_WIDTH   8
`define PORT_THREE_WIDTH 4
`define PORT_ONE_HIGH_LO 4
`define PORT_TWO_ZERO    0
`define PORT_THREE_TOP   3
`define MODE_WIDTH       3

// Per-line mode codes
`define MODE_IN_FLOAT   3'h0
`define MODE_IN_PULLUP  3'h1
`define MODE_IN_IRQ     3'h2
`define MODE_OUT_OD     3'h3
`define MODE_OUT_PP     3'h4
`define MODE_ANALOG     3'h5

`define ZERO8 8'h00
`define ZERO4 4'h0

`endif

// *** hdl/pin_function_config_pkg.sv ***
// Types shared by the pin function block.
// Assumes the constants header is on the include path.
`include "pin_function_config_consts.svh"

package pin_function_config_pkg;

  typedef logic [`MODE_WIDTH-1:0] line_mode_t;

  // Per-port pad controls travel together
  typedef struct packed {
    logic [`PORT_ONE_WIDTH-1:0] out;
    logic [`PORT_ONE_WIDTH-1:0] oe;
    logic [`PORT_ONE_WIDTH-1:0] pull;
    logic [`PORT_ONE_WIDTH-1:0] ana;
    logic [`PORT_ONE_WIDTH-1:0] din;
    logic [`PORT_ONE_WIDTH-1:0] irq;
  } pad8_t;

  typedef struct packed {
    logic [`PORT_THREE_WIDTH-1:0] out;
    logic [`PORT_THREE_WIDTH-1:0] oe;
    logic [`PORT_THREE_WIDTH-1:0] pull;
    logic [`PORT_THREE_WIDTH-1:0] ana;
    logic [`PORT_THREE_WIDTH-1:0] din;
    logic [`PORT_THREE_WIDTH-1:0] irq;
  } pad4_t;

  typedef struct packed {
    pad8_t p1;
    pad8_t p2;
    pad4_t p3;
    logic  nmi_s1;
    logic  nmi_prev;
    logic  nmi_pend;
    logic  tmr_ext;
    logic  tmr_out;
    logic  tmr_oe;
    logic  test_mode;
  } state_t;

endpackage : pin_function_config_pkg

// *** test/board_model.sv ***
// Board side of one port: pads, outside sources, pull-ups, test strap.
// Assumes pad controls from the block and the core clock.
`timescale 1ns/1ps
module board_model #(parameter int W = 8) (
  input  wire logic         clock_i,                        // Pattern clock
  input  wire logic [W-1:0] oe_i, out_i, pull_i, src_i, src_en_i, // Pad controls, sources
  output logic      [W-1:0] pin_o,                          // Resolved pad level
  output logic              test_o                          // Test strap
);
  logic [W-1:0] flt_q = '0;
  // Floating lines wander, so a stale level is never read as valid
  always_ff @(posedge clock_i) flt_q <= ~flt_q;
  // Block drive wins, then a source, then the pull-up
  always_comb for (int i = 0; i < W; i++)
    pin_o[i] = oe_i[i] ? out_i[i] : src_en_i[i] ? src_i[i] : pull_i[i] ? 1'b1 : flt_q[i];
  assign test_o = 1'b0; // Strap at ground
endmodule : board_model

// *** test/pin_function_config_sva.sv ***
// Checker for the pin block: decode, forced open-drain, NMI, timer, reset pin.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`include "pin_function_config_consts.svh"
module pin_function_config_sva #(parameter bit STOP_CTRL_OPTION = 1'b0) (
  input wire logic clock_i, rst_i, reset_pin_n_i, nmi_pin_i, nmi_ack_i, nmi_req_o, // Core, NMI
  input wire logic timer_out_mode_i, timer_timeout_i, timer_data_bit_i, timer_pin_i, // Timer in
  input wire logic timer_ext_o, timer_out_o, timer_oe_o,                        // Timer out
  input wire logic [`PORT_ONE_WIDTH*`MODE_WIDTH-1:0] p1_mode_i, p2_mode_i,     // Modes
  input wire logic [`PORT_THREE_WIDTH*`MODE_WIDTH-1:0] p3_mode_i,              // Modes
  input wire logic [`PORT_ONE_WIDTH-1:0] p1_data_i, p1_out_o, p1_oe_o, p1_ana_o, // Port one
  input wire logic [`PORT_TWO_WIDTH-1:0] p2_data_i, p2_out_o, p2_oe_o,         // Port two
  input wire logic [`PORT_THREE_WIDTH-1:0] p3_data_i, p3_out_o, p3_oe_o        // Port three
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i || !reset_pin_n_i);
  // A falling pad with no ack for the synchroniser span
  sequence s_nmi_fall; $fell(nmi_pin_i) ##1 (!nmi_ack_i) [*3]; endsequence
  AST_P1_PUSH: assert property (p1_mode_i[2:0] == `MODE_OUT_PP |=> p1_oe_o[0] && p1_out_o[0] == $past(p1_data_i[0]))
    else $error("push-pull line wrong");
  AST_P1_OPEN: assert property (p1_mode_i[5:3] == `MODE_OUT_OD |=> !p1_out_o[1] && p1_oe_o[1] == !$past(p1_data_i[1]))
    else $error("open-drain line wrong");
  AST_P1_ANALOG: assert property (p1_mode_i[14:12] == `MODE_ANALOG && p1_mode_i[2:0] == `MODE_ANALOG |=> p1_ana_o[4] && !p1_ana_o[0])
    else $error("analog select wrong");
  AST_P2_PUSH: assert property (p2_mode_i[5:3] == `MODE_OUT_PP |=> p2_oe_o[1] && p2_out_o[1] == $past(p2_data_i[1]))
    else $error("second port push-pull wrong");
  AST_P2_FORCED: assert property (STOP_CTRL_OPTION && p2_mode_i[2:0] == `MODE_OUT_PP |=> !p2_out_o[0] && p2_oe_o[0] == !$past(p2_data_i[0]))
    else $error("second port line zero not open-drain");
  AST_P3_FORCED: assert property (STOP_CTRL_OPTION && p3_mode_i[11:9] == `MODE_OUT_PP |=> !p3_out_o[3] && p3_oe_o[3] == !$past(p3_data_i[3]))
    else $error("third port top line not open-drain");
  AST_NMI_FALL: assert property (s_nmi_fall |-> nmi_req_o)
    else $error("falling NMI not caught");
  AST_NMI_EDGE_ONLY: assert property ($rose(nmi_req_o) |-> !$past(nmi_pin_i, 2))
    else $error("NMI raised without a fall");
  AST_TMR_IN: assert property (!timer_out_mode_i |=> timer_ext_o == $past(timer_pin_i) && !timer_oe_o)
    else $error("timer pin not fed to prescaler");
  AST_TMR_OUT: assert property (timer_out_mode_i && timer_timeout_i |=> timer_oe_o && timer_out_o == $past(timer_data_bit_i))
    else $error("timer data bit not driven");
  AST_RST_PIN: assert property (disable iff (rst_i) !reset_pin_n_i |-> !nmi_req_o && !timer_oe_o && p1_oe_o == 8'h00)
    else $error("reset pin did not restart");
endmodule : pin_function_config_sva

bind pin_function_config pin_function_config_sva #(.STOP_CTRL_OPTION(STOP_CTRL_OPTION)) u_sva (.clock_i, .rst_i,
  .reset_pin_n_i, .nmi_pin_i, .nmi_ack_i, .nmi_req_o, .timer_out_mode_i, .timer_timeout_i, .timer_data_bit_i,
  .timer_pin_i, .timer_ext_o, .timer_out_o, .timer_oe_o, .p1_mode_i, .p2_mode_i, .p3_mode_i, .p1_data_i,
  .p1_out_o, .p1_oe_o, .p1_ana_o, .p2_data_i, .p2_out_o, .p2_oe_o, .p3_data_i, .p3_out_o, .p3_oe_o);

// *** test/pin_function_config_tb.sv ***
// Self-checking bench for the pin block, built with the stop control option.
// Assumes the board model on every port and the bound checker.
`timescale 1ns/1ps
`include "pin_function_config_consts.svh"
module pin_function_config_tb;
  import pin_function_config_pkg::*;
  logic clock_i = 0, rst_i = 1, rst_n = 1, nmi = 1, ack = 0, tmode = 0, tout = 0, tbit = 0, tpin = 0, sen = 0;
  logic [23:0] m1 = '0, m2 = '0;
  logic [11:0] m3 = '0;
  logic [7:0]  d8 = 8'hA5, s8 = 8'h3C;
  logic [3:0]  d3 = 4'h5;
  wire  [7:0]  o1, e1, u1, a1, i1, q1, o2, e2, u2, a2, i2, q2, pin1, pin2;
  wire  [3:0]  o3, e3, u3, a3, i3, q3, pin3;
  wire         nreq, text, tvo, toe, tst, tmo;
  int          n_mismatch = 0, checks_done = 0;
  always #4 clock_i = ~clock_i;
  board_model #(.W(8)) b1 (.clock_i, .oe_i(e1), .out_i(o1), .pull_i(u1), .src_i(s8), .src_en_i({8{sen}}),
    .pin_o(pin1), .test_o(tst));
  board_model #(.W(8)) b2 (.clock_i, .oe_i(e2), .out_i(o2), .pull_i(u2), .src_i(s8), .src_en_i({8{sen}}),
    .pin_o(pin2), .test_o());
  board_model #(.W(4)) b3 (.clock_i, .oe_i(e3), .out_i(o3), .pull_i(u3), .src_i(s8[3:0]), .src_en_i({4{sen}}),
    .pin_o(pin3), .test_o());
  // Option fixed at build time
  pin_function_config #(.STOP_CTRL_OPTION(1'b1), .LARGE_PACKAGE(1'b1)) dut (.clock_i, .rst_i, .reset_pin_n_i(rst_n),
    .p1_mode_i(m1), .p2_mode_i(m2), .p3_mode_i(m3), .p1_data_i(d8), .p2_data_i(d8), .p3_data_i(d3),
    .p1_pin_i(pin1), .p2_pin_i(pin2), .p3_pin_i(pin3), .nmi_pin_i(nmi), .nmi_ack_i(ack),
    .timer_out_mode_i(tmode), .timer_timeout_i(tout), .timer_data_bit_i(tbit), .timer_pin_i(tpin),
    .test_pin_i(tst), .p1_out_o(o1), .p1_oe_o(e1), .p1_pull_o(u1), .p1_ana_o(a1), .p1_din_o(i1), .p1_irq_o(q1),
    .p2_out_o(o2), .p2_oe_o(e2), .p2_pull_o(u2), .p2_ana_o(a2), .p2_din_o(i2), .p2_irq_o(q2),
    .p3_out_o(o3), .p3_oe_o(e3), .p3_pull_o(u3), .p3_ana_o(a3), .p3_din_o(i3), .p3_irq_o(q3),
    .nmi_req_o(nreq), .timer_ext_o(text), .timer_out_o(tvo), .timer_oe_o(toe), .test_mode_o(tmo));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Settle past the edge so launched updates have landed
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step
  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    // Every mode on every line; pads loop back, so din needs an extra cycle
    for (int m = 0; m < 6; m++) begin
      @(posedge clock_i);
      m1 <= {8{3'(m)}};
      m2 <= {8{3'(m)}};
      m3 <= {4{3'(m)}};
      sen <= (m < 3 || m == 5);
      step(3);
      chk({e1, e2, e3}, m == 4 ? 20'hFFFEF : m == 3 ? 20'h5A5AA : 20'h0, "enable");
      chk({o1, o2, o3}, m == 4 ? 20'hA5A45 : 20'h0, "drive");
      chk({u1, u2, u3}, (m == 1 || m == 2) ? 20'hFFFFF : 20'h0, "pull");
      chk({a1, a2, a3}, m == 5 ? 20'hF0FFF : 20'h0, "analog");
      chk({q1, q2, q3}, m == 2 ? 20'hC3C33 : 20'h0, "irq");
      if (m != 3 && m != 4) chk({i1, i2, i3}, m == 5 ? 20'h0C000 : 20'h3C3CC, "read");
    end
    $display("Test decode done");
    @(posedge clock_i);
    nmi <= 1'b0;
    step(4);
    chk({19'h0, nreq}, 20'h1, "nmi set");
    @(posedge clock_i);
    ack <= 1'b1;
    @(posedge clock_i);
    ack <= 1'b0;
    nmi <= 1'b1;
    step(5);
    chk({19'h0, nreq}, 20'h0, "nmi rise ignored");
    $display("Test nmi done");
    @(posedge clock_i);
    tpin <= 1'b1;
    step(2);
    chk({18'h0, toe, text}, 20'h1, "timer in");
    @(posedge clock_i);
    tmode <= 1'b1;
    tbit <= 1'b1;
    tout <= 1'b1;
    @(posedge clock_i);
    tout <= 1'b0;
    tbit <= 1'b0;
    step(2);
    chk({18'h0, toe, tvo}, 20'h3, "timer out");
    chk({19'h0, tmo}, 20'h0, "test strap");
    $display("Test timer done");
    @(posedge clock_i);
    rst_n <= 1'b0;
    step(1);
    chk({18'h0, toe, tvo}, 20'h0, "reset pin");
    @(posedge clock_i);
    rst_n <= 1'b1;
    step(3);
    chk({18'h0, toe, tvo}, 20'h2, "restart");
    $display("Test reset done");
    print_verdict();
  end
  // Run needs under 100 cycles; a hang is cut off well after that
  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end
endmodule : pin_function_config_tb
